// [verilog/lcd_serial_core.sv]
// Serial command core of a 32x4 segment LCD driver
// What this block does
// - Hold 32 four-bit display words mapped straight onto segment and common outputs.
// - Display memory is reached only by serial read, write and read-modify-write.
// - Time base and watchdog run from one shared divide-by-256 prescaler.
// - Timer, watchdog and interrupt enables act independently; interrupt disable also clears the watchdog flag.
// - After watchdog time-out interrupt stays low until watchdog clear or interrupt disable.
// - Tone generator drives a complementary output pair.
// - Software selects half or third bias and two, three or four commons.
// - LCD scan clock is divided from the oscillator to 256 Hz.
// - Display-off disables the bias generator; display-on enables it.
// - Bias bit 0 means half bias, 1 means third bias.
// - Commons field 00, 01, 10 selects two, three, four commons.
// - Every transfer opens with ID 110 read, 101 write, 100 command.
// - After a first command, further nine-bit groups are further commands.
// - Chip select high ignores traffic and resets the serial state.
// - Each read strobe falling edge shifts the next memory bit out.
// - ID, address, data and command bits are taken on write strobe rise.
// - Interrupt pin carries time base clock or watchdog flag by software choice.
// - Address six bits MSB first, then four data bits LSB first.
// - Command 0000111x clears the watchdog stage.
// - Frequency select sets 1 Hz to 128 Hz time base, 128 Hz default.
// - System enable starts the oscillator, which is off after reset.
`timescale 1ns/1ps
`default_nettype none
module lcd_serial_core
  import lcd_cmd_pkg::*;
#(
  parameter int OSC_DIV = OSC_TICK_CYC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic link_clk_i,
  input wire logic cs_n_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  input wire logic data_i,
  output logic data_o,
  output logic data_oe_o,
  output logic irq_o,
  output logic irq_oe_o,
  output logic [1:0] tone_out_pair_o,
  output logic tone_out_pair_oe_o,
  output logic [RAM_WORDS-1:0] seg_o,
  output logic [3:0] com_o,
  output logic osc_on_o,
  output logic bias_gen_on_o,
  output logic bias_third_o,
  output logic [1:0] commons_sel_o
);
  // ===========================================================
  // Link domain: pin sync and edges
  // ===========================================================
  logic [3:0] pins_s;
  logic [3:0] scan_s;
  logic cs_s, wr_s, rd_s, data_s, lrst;
  logic wr_d_reg, rd_d_reg;
  logic wr_rise, wr_fall, rd_fall;
  logic [1:0] com_q_reg;
  logic display_on_cmd_l_reg;
  logic [COM_W-1:0] com_idx_reg;
  logic display_on_cmd_reg;

  sync2 #(.W(4), .RST_VAL(4'hF)) u_pin_sync (
    .clk_i(link_clk_i),
    .rst_i(lrst),
    .en_i(1'b1),
    .d_i({cs_n_i, wr_n_i, rd_n_i, data_i}),
    .q_o(pins_s)
  );

  sync2 #(.W(4), .RST_VAL(4'h0)) u_scan_sync (
    .clk_i(link_clk_i),
    .rst_i(1'b0),
    .en_i(1'b1),
    .d_i({srst_i, display_on_cmd_reg, com_idx_reg}),
    .q_o(scan_s)
  );

  assign lrst = scan_s[3];
  assign cs_s = pins_s[3];
  assign wr_s = pins_s[2];
  assign rd_s = pins_s[1];
  assign data_s = pins_s[0];
  assign wr_rise = wr_s & ~wr_d_reg;
  assign wr_fall = ~wr_s & wr_d_reg;
  assign rd_fall = ~rd_s & rd_d_reg;

  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      wr_d_reg <= 1'b1;
      rd_d_reg <= 1'b1;
    end else begin
      wr_d_reg <= wr_s;
      rd_d_reg <= rd_s;
    end
  end

  // ===========================================================
  // Link domain: serial protocol
  // ===========================================================
  link_state_t state_reg;
  logic [CNT_W-1:0] bit_cnt_reg;
  logic [1:0] rbit_reg;
  logic [CMD_BITS-1:0] shift_reg;
  logic [ADDR_BITS-1:0] addr_reg;
  logic [WORD_W-1:0] wbits_reg;
  logic [CMD_W-1:0] cmd_word_reg;
  logic cmd_tgl_reg;
  logic [CMD_BITS-1:0] shift_next;
  logic ram_we;
  logic [WORD_W-1:0] ram_wdata, ram_rdata;
  logic [RAM_WORDS-1:0] col;

  assign shift_next = {shift_reg[CMD_BITS-2:0], data_s};
  assign ram_we = (state_reg == ST_WRITE) && wr_rise &&
                  (bit_cnt_reg == CNT_W'(WORD_W - 1));
  assign ram_wdata = {data_s, wbits_reg[WORD_W-1:1]};

  display_ram u_ram (
    .clk_i(link_clk_i),
    .we_i(ram_we),
    .addr_i(addr_reg[RAM_AW-1:0]),
    .wdata_i(ram_wdata),
    .rdata_o(ram_rdata),
    .col_sel_i(com_q_reg),
    .col_o(col)
  );

  always_ff @(posedge link_clk_i) begin
    if (lrst || cs_s) begin
      state_reg <= ST_ID;
      bit_cnt_reg <= '0;
      rbit_reg <= '0;
      shift_reg <= '0;
      addr_reg <= '0;
      wbits_reg <= '0;
      data_o <= 1'b1;
      data_oe_o <= 1'b0;
    end else begin
      case (state_reg)
        ST_ID: begin
          if (wr_rise) begin
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            if (bit_cnt_reg == CNT_W'(ID_BITS - 1)) begin
              bit_cnt_reg <= '0;
              if (shift_next[2:0] == ID_READ) begin
                state_reg <= ST_ADDR;
              end else if (shift_next[2:0] == ID_WRITE) begin
                state_reg <= ST_ADDR;
              end else if (shift_next[2:0] == ID_CMD) begin
                state_reg <= ST_CMD;
              end else begin
                state_reg <= ST_IGNORE;
              end
            end
          end
        end
        ST_ADDR: begin
          if (wr_rise) begin
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            if (bit_cnt_reg == CNT_W'(ADDR_BITS - 1)) begin
              bit_cnt_reg <= '0;
              addr_reg <= shift_next[ADDR_BITS-1:0];
              // ID bits still sit above the address in the shifter
              state_reg <= (shift_next[ADDR_BITS+:ID_BITS] == ID_READ) ? ST_READ : ST_WRITE;
            end
          end
        end
        ST_READ: begin
          if (rd_fall) begin
            data_o <= ram_rdata[rbit_reg];
            data_oe_o <= 1'b1;
            rbit_reg <= rbit_reg + 1'b1;
            if (rbit_reg == 2'(WORD_W - 1)) begin
              addr_reg <= addr_reg + 1'b1;
            end
          end
        end
        ST_WRITE: begin
          if (rd_fall) begin
            data_o <= ram_rdata[rbit_reg];
            data_oe_o <= 1'b1;
            rbit_reg <= rbit_reg + 1'b1;
          end else if (wr_fall) begin
            data_oe_o <= 1'b0;
          end
          if (wr_rise) begin
            wbits_reg <= ram_wdata;
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            if (ram_we) begin
              bit_cnt_reg <= '0;
              rbit_reg <= '0;
              addr_reg <= addr_reg + 1'b1;
            end
          end
        end
        ST_CMD: begin
          if (wr_rise) begin
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            if (bit_cnt_reg == CNT_W'(CMD_BITS - 1)) begin
              bit_cnt_reg <= '0;
            end
          end
        end
        ST_IGNORE: begin
          state_reg <= ST_IGNORE;
        end
        default: begin
          state_reg <= ST_ID;
        end
      endcase
    end
  end

  // Command word held until the next one; toggle marks a new word
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      cmd_word_reg <= '0;
      cmd_tgl_reg <= 1'b0;
    end else if (!cs_s && state_reg == ST_CMD && wr_rise &&
                 bit_cnt_reg == CNT_W'(CMD_BITS - 1)) begin
      cmd_word_reg <= shift_reg[CMD_W-1:0];
      cmd_tgl_reg <= ~cmd_tgl_reg;
    end
  end

  // Scan index accepted only when two synced samples agree
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      com_q_reg <= '0;
      display_on_cmd_l_reg <= 1'b0;
      seg_o <= '0;
      com_o <= '0;
    end else begin
      if (scan_s[2:0] == {display_on_cmd_l_reg, com_q_reg}) begin
        seg_o <= display_on_cmd_l_reg ? col : '0;
        com_o <= display_on_cmd_l_reg ? (4'h1 << com_q_reg) : 4'h0;
      end
      com_q_reg <= scan_s[1:0];
      display_on_cmd_l_reg <= scan_s[2];
    end
  end

  // ===========================================================
  // System domain: command decode
  // ===========================================================
  logic cmd_tgl_s, cmd_tgl_d_reg, cmd_pulse;
  logic [CMD_W-1:0] cmd;
  logic osc_on_reg, timer_en_reg, watchdog_en_reg, irq_en_reg;
  logic tone_en_reg, tone_4k_reg, bias_third_reg;
  logic [2:0] fsel_reg;
  logic [1:0] coms_reg;
  logic tmr_clr_cmd, watchdog_clear_cmd, interrupt_out_disable_cmd;

  sync2 #(.W(1), .RST_VAL(1'b0)) u_cmd_sync (
    .clk_i(clk_i),
    .rst_i(srst_i),
    .en_i(ce_i),
    .d_i(cmd_tgl_reg),
    .q_o(cmd_tgl_s)
  );

  assign cmd_pulse = cmd_tgl_s ^ cmd_tgl_d_reg;
  assign cmd = cmd_word_reg;
  assign tmr_clr_cmd = cmd_pulse && cmd == CMD_TMR_CLR;
  assign watchdog_clear_cmd = cmd_pulse && cmd[7:1] == CMD_WDG_CLR_HI;
  assign interrupt_out_disable_cmd = cmd_pulse && cmd[7:5] == GRP_IRQ &&
                                     !cmd[IRQ_EN_BIT];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cmd_tgl_d_reg <= 1'b0;
      osc_on_reg <= 1'b0;
      display_on_cmd_reg <= 1'b0;
      timer_en_reg <= 1'b0;
      watchdog_en_reg <= 1'b0;
      irq_en_reg <= 1'b0;
      tone_en_reg <= 1'b0;
      tone_4k_reg <= 1'b0;
      fsel_reg <= FSEL_RST;
      bias_third_reg <= BIAS_RST;
      coms_reg <= COMS_RST;
    end else if (ce_i) begin
      cmd_tgl_d_reg <= cmd_tgl_s;
      if (cmd_pulse) begin
        if (cmd == CMD_SYS_DIS) begin
          osc_on_reg <= 1'b0;
          display_on_cmd_reg <= 1'b0;
        end else if (cmd == CMD_OSCILLATOR_ON_CMD) begin
          osc_on_reg <= 1'b1;
        end else if (cmd == CMD_DISPLAY_OFF_CMD) begin
          display_on_cmd_reg <= 1'b0;
        end else if (cmd == CMD_DISPLAY_ON_CMD) begin
          display_on_cmd_reg <= 1'b1;
        end else if (cmd == CMD_TMR_DIS) begin
          timer_en_reg <= 1'b0;
        end else if (cmd == CMD_WDG_DIS) begin
          watchdog_en_reg <= 1'b0;
        end else if (cmd == CMD_TMR_EN) begin
          timer_en_reg <= 1'b1;
        end else if (cmd == CMD_WDG_EN) begin
          watchdog_en_reg <= 1'b1;
        end else if (cmd == CMD_TONE_OFF) begin
          tone_en_reg <= 1'b0;
        end else if (cmd[7:4] == GRP_BIAS) begin
          bias_third_reg <= cmd[BIAS_BIT];
          if (cmd[COMS_LSB+:2] != COMS_BAD) begin
            coms_reg <= cmd[COMS_LSB+:2];
          end
        end else if (cmd[7:5] == GRP_TONE4K) begin
          tone_en_reg <= 1'b1;
          tone_4k_reg <= 1'b1;
        end else if (cmd[7:4] == GRP_TONE2K) begin
          tone_en_reg <= 1'b1;
          tone_4k_reg <= 1'b0;
        end else if (cmd[7:5] == GRP_IRQ) begin
          irq_en_reg <= cmd[IRQ_EN_BIT];
        end else if (cmd[7:5] == GRP_FSEL && !cmd[FSEL_ZERO_BIT]) begin
          fsel_reg <= cmd[2:0];
        end
      end
    end
  end

  // ===========================================================
  // System domain: oscillator, prescaler, time base, watchdog
  // ===========================================================
  logic [OSC_CNT_W-1:0] osc_cnt_reg;
  logic osc_tick;
  logic [PRESCALE_W-1:0] prescale_reg;
  logic [TB_W-1:0] tb_reg;
  logic [TB_W:0] tb_vec;
  logic tb_clk, tb_clk_d_reg, tb_rise;
  logic [1:0] watchdog_cnt_reg;
  logic watchdog_flag_reg, watchdog_timeout;

  assign osc_tick = osc_on_reg && osc_cnt_reg == OSC_CNT_W'(OSC_DIV - 1);

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      osc_cnt_reg <= '0;
      prescale_reg <= '0;
    end else if (ce_i && osc_on_reg) begin
      osc_cnt_reg <= osc_tick ? '0 : osc_cnt_reg + 1'b1;
      if (osc_tick) begin
        prescale_reg <= prescale_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || (ce_i && tmr_clr_cmd)) begin
      tb_reg <= '0;
    end else if (ce_i && osc_tick && prescale_reg == '1) begin
      tb_reg <= tb_reg + 1'b1;
    end
  end

  // Tap k of tb_vec gives 2^k Hz
  assign tb_vec[TB_W] = prescale_reg[PRESCALE_W-1];
  for (genvar k = 0; k < TB_W; k++) begin : g_tap
    assign tb_vec[k] = tb_reg[TB_W-1-k];
  end
  assign tb_clk = tb_vec[fsel_reg];
  assign tb_rise = tb_clk & ~tb_clk_d_reg;
  assign watchdog_timeout = tb_rise && watchdog_cnt_reg == WDG_LAST;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      tb_clk_d_reg <= 1'b0;
      watchdog_cnt_reg <= '0;
      watchdog_flag_reg <= 1'b0;
    end else if (ce_i) begin
      tb_clk_d_reg <= tb_clk;
      if (watchdog_clear_cmd) begin
        watchdog_cnt_reg <= '0;
      end else if (tb_rise) begin
        watchdog_cnt_reg <= watchdog_cnt_reg + 1'b1;
      end
      // Set wins over a clear in the same cycle
      if (watchdog_timeout) begin
        watchdog_flag_reg <= 1'b1;
      end else if (watchdog_clear_cmd || interrupt_out_disable_cmd) begin
        watchdog_flag_reg <= 1'b0;
      end
    end
  end

  // ===========================================================
  // System domain: scan, interrupt pin, tone, LCD levels
  // ===========================================================
  logic lcd_tick;

  assign lcd_tick = osc_tick && prescale_reg[6:0] == LCD_TICK_MASK;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      com_idx_reg <= '0;
      irq_oe_o <= 1'b0;
      tone_out_pair_o <= 2'h0;
      tone_out_pair_oe_o <= 1'b0;
    end else if (ce_i) begin
      if (lcd_tick) begin
        com_idx_reg <= (com_idx_reg >= coms_reg + 2'h1) ? '0 : com_idx_reg + 1'b1;
      end
      irq_oe_o <= irq_en_reg &&
                  ((watchdog_en_reg && watchdog_flag_reg) ||
                   (timer_en_reg && !tb_clk));
      tone_out_pair_oe_o <= tone_en_reg;
      if (tone_en_reg) begin
        tone_out_pair_o <= tone_4k_reg ?
          {~prescale_reg[TONE_4K_BIT], prescale_reg[TONE_4K_BIT]} :
          {~prescale_reg[TONE_2K_BIT], prescale_reg[TONE_2K_BIT]};
      end else begin
        tone_out_pair_o <= 2'h0;
      end
    end
  end

  assign irq_o = 1'b0;
  assign osc_on_o = osc_on_reg;
  assign bias_gen_on_o = display_on_cmd_reg;
  assign bias_third_o = bias_third_reg;
  assign commons_sel_o = coms_reg;
endmodule // lcd_serial_core
`default_nettype wire

// [verilog/lcd_cmd_pkg.sv]
// Constants and types shared by the segment LCD serial command core
package lcd_cmd_pkg;
  // ===========================================================
  // Clocking
  // ===========================================================
  localparam int CLK_HZ = 100_000_000;
  localparam int OSC_HZ = 32768;
  localparam int OSC_TICK_CYC = CLK_HZ / OSC_HZ;
  localparam int OSC_CNT_W = 12;
  // ===========================================================
  // Display memory and serial frame
  // ===========================================================
  localparam int RAM_WORDS = 32;
  localparam int RAM_AW = 5;
  localparam int WORD_W = 4;
  localparam int COM_W = 2;
  localparam int ADDR_BITS = 6;
  localparam int ID_BITS = 3;
  localparam int CMD_BITS = 9;
  localparam int CMD_W = 8;
  localparam int CNT_W = 4;
  localparam logic [2:0] ID_READ = 3'h6;
  localparam logic [2:0] ID_WRITE = 3'h5;
  localparam logic [2:0] ID_CMD = 3'h4;
  // ===========================================================
  // Command codes
  // ===========================================================
  localparam logic [7:0] CMD_SYS_DIS = 8'h00;
  localparam logic [7:0] CMD_OSCILLATOR_ON_CMD = 8'h01;
  localparam logic [7:0] CMD_DISPLAY_OFF_CMD = 8'h02;
  localparam logic [7:0] CMD_DISPLAY_ON_CMD = 8'h03;
  localparam logic [7:0] CMD_TMR_DIS = 8'h04;
  localparam logic [7:0] CMD_WDG_DIS = 8'h05;
  localparam logic [7:0] CMD_TMR_EN = 8'h06;
  localparam logic [7:0] CMD_WDG_EN = 8'h07;
  localparam logic [7:0] CMD_TONE_OFF = 8'h08;
  localparam logic [7:0] CMD_TMR_CLR = 8'h0D;
  localparam logic [6:0] CMD_WDG_CLR_HI = 7'h07;
  localparam logic [3:0] GRP_BIAS = 4'h2;
  localparam logic [3:0] GRP_TONE2K = 4'h6;
  localparam logic [2:0] GRP_TONE4K = 3'h2;
  localparam logic [2:0] GRP_IRQ = 3'h4;
  localparam logic [2:0] GRP_FSEL = 3'h5;
  localparam int IRQ_EN_BIT = 3;
  localparam int FSEL_ZERO_BIT = 3;
  localparam int BIAS_BIT = 0;
  localparam int COMS_LSB = 2;
  localparam logic [1:0] COMS_BAD = 2'h3;
  // ===========================================================
  // Reset values and timer taps
  // ===========================================================
  localparam logic [2:0] FSEL_RST = 3'h7;
  localparam logic [1:0] COMS_RST = 2'h2;
  localparam logic BIAS_RST = 1'b0;
  localparam int PRESCALE_W = 8;
  localparam int TB_W = 7;
  localparam int TONE_4K_BIT = 2;
  localparam int TONE_2K_BIT = 3;
  localparam logic [6:0] LCD_TICK_MASK = 7'h7F;
  localparam logic [1:0] WDG_LAST = 2'h3;
  typedef enum logic [5:0] {
    ST_ID = 6'h01,
    ST_ADDR = 6'h02,
    ST_READ = 6'h04,
    ST_WRITE = 6'h08,
    ST_CMD = 6'h10,
    ST_IGNORE = 6'h20
  } link_state_t;
endpackage

// [verilog/sync2.sv]
// Two flip-flop synchroniser for slow levels
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_reg <= RST_VAL;
      q_o <= RST_VAL;
    end else if (en_i) begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end
endmodule // sync2
`default_nettype wire

// [verilog/display_ram.sv]
// Display memory with serial port and per-common column read
`timescale 1ns/1ps
`default_nettype none
module display_ram
  import lcd_cmd_pkg::*;
#(
  parameter int WORDS = RAM_WORDS,
  parameter int AW = RAM_AW,
  parameter int DW = WORD_W
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o,
  input wire logic [COM_W-1:0] col_sel_i,
  output logic [WORDS-1:0] col_o
);
  logic [DW-1:0] mem [WORDS];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[addr_i] <= wdata_i;
    end
  end

  assign rdata_o = mem[addr_i];

  // One segment bit per word for the active common
  for (genvar i = 0; i < WORDS; i++) begin : g_col
    assign col_o[i] = mem[i][col_sel_i];
  end
endmodule // display_ram
`default_nettype wire

// [testbench/lcd_serial_core_sva.sv]
// Port assertions for the serial LCD command core
`timescale 1ns/1ps
`default_nettype none
module lcd_serial_core_sva
  import lcd_cmd_pkg::*;
#(
  parameter int OSC_DIV = OSC_TICK_CYC
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic link_clk_i,
  input wire logic cs_n_i,
  input wire logic wr_n_i,
  input wire logic data_oe_o,
  input wire logic irq_o,
  input wire logic irq_oe_o,
  input wire logic [1:0] tone_out_pair_o,
  input wire logic tone_out_pair_oe_o,
  input wire logic [RAM_WORDS-1:0] seg_o,
  input wire logic [3:0] com_o,
  input wire logic osc_on_o,
  input wire logic bias_gen_on_o,
  input wire logic bias_third_o,
  input wire logic [1:0] commons_sel_o
);
  chk_irq_pull_only: assert property (
    @(posedge clk_i) disable iff (srst_i) irq_o == 1'b0) else $error("irq value not low");
  chk_tone_pair_diff: assert property (
    @(posedge clk_i) disable iff (srst_i) tone_out_pair_oe_o && $past(tone_out_pair_oe_o)
    |-> tone_out_pair_o[1] != tone_out_pair_o[0]) else $error("tone pair not complementary");
  chk_commons_legal: assert property (
    @(posedge clk_i) disable iff (srst_i) commons_sel_o != COMS_BAD) else $error("bad commons");
  chk_reset_defaults: assert property (
    @(posedge clk_i) disable iff (srst_i) $fell(srst_i) |-> !osc_on_o && !bias_gen_on_o
    && !bias_third_o && commons_sel_o == COMS_RST && !irq_oe_o) else $error("reset defaults");
  chk_cfg_hold_cs: assert property (
    @(posedge clk_i) disable iff (srst_i) cs_n_i [*8] |-> $stable(bias_third_o)
    && $stable(commons_sel_o) && $stable(bias_gen_on_o) && $stable(osc_on_o))
    else $error("config changed while deselected");
  chk_dark_when_off: assert property (
    @(posedge link_clk_i) disable iff (srst_i) (!bias_gen_on_o) [*6]
    |-> seg_o == '0 && com_o == 4'h0) else $error("display not blank when off");
  chk_com_onehot: assert property (
    @(posedge link_clk_i) disable iff (srst_i) $onehot0(com_o)) else $error("com not one-hot");
  chk_oe_cs_idle: assert property (
    @(posedge link_clk_i) disable iff (srst_i) cs_n_i [*4] |-> !data_oe_o)
    else $error("data driven while deselected");
  chk_oe_wr_low: assert property (
    @(posedge link_clk_i) disable iff (srst_i) (!wr_n_i) [*6] |-> !data_oe_o)
    else $error("data driven during write strobe");
endmodule // lcd_serial_core_sva
bind lcd_serial_core lcd_serial_core_sva #(.OSC_DIV(OSC_DIV)) sva_inst (
  .clk_i(clk_i), .srst_i(srst_i), .link_clk_i(link_clk_i), .cs_n_i(cs_n_i), .wr_n_i(wr_n_i),
  .data_oe_o(data_oe_o), .irq_o(irq_o), .irq_oe_o(irq_oe_o), .tone_out_pair_o(tone_out_pair_o),
  .tone_out_pair_oe_o(tone_out_pair_oe_o), .seg_o(seg_o), .com_o(com_o), .osc_on_o(osc_on_o),
  .bias_gen_on_o(bias_gen_on_o), .bias_third_o(bias_third_o), .commons_sel_o(commons_sel_o)
);
`default_nettype wire

// [testbench/lcd_host_model.sv]
// Behavioural host driving the serial pins
`timescale 1ns/1ps
`default_nettype none
module lcd_host_model (
  input wire logic clk_i,
  input wire logic data_i,
  output logic cs_n_o,
  output logic wr_n_o,
  output logic rd_n_o,
  output logic data_o,
  output logic data_oe_o
);
  // Strobe half period in clk_i cycles, rate scaled up for simulation
  int half = 40;
  initial begin
    cs_n_o = 1'b1;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    data_o = 1'b1;
    data_oe_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // High pulse on select, then select
  task automatic start();
    cs_n_o <= 1'b1;
    data_oe_o <= 1'b0;
    tick(half);
    cs_n_o <= 1'b0;
    tick(half);
  endtask
  task automatic stop();
    tick(half);
    cs_n_o <= 1'b1;
    data_oe_o <= 1'b0;
    tick(half);
  endtask
  // MSB first, data held across the strobe rise
  task automatic send(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      data_oe_o <= 1'b1;
      data_o <= v[i];
      wr_n_o <= 1'b0;
      tick(half);
      wr_n_o <= 1'b1;
      tick(half);
    end
  endtask
  // LSB first, sampled late in the strobe high phase
  task automatic recv(output logic [3:0] v);
    data_oe_o <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd_n_o <= 1'b0;
      tick(half);
      rd_n_o <= 1'b1;
      tick(half);
      v[i] = data_i;
    end
  endtask
endmodule // lcd_host_model
`default_nettype wire

// [testbench/lcd_serial_core_tb.sv]
// Self-checking bench for the serial LCD core
`timescale 1ns/1ps
`default_nettype none
module lcd_serial_core_tb;
  import lcd_cmd_pkg::*;
  localparam int LIMIT = 90000;
  logic clk_i, link_clk_i, srst_i, ce_i, cs_n, wr_n, rd_n, h_d, h_oe, d_o, d_oe;
  logic irq_o, irq_oe, tone_oe, osc_on, bias_on, third, c;
  logic [1:0] tone, coms, ab, exp_coms;
  logic [RAM_WORDS-1:0] seg;
  logic [3:0] com, v, d;
  logic [3:0] mem [0:31];
  logic [5:0] a;
  wire logic data_w;
  int n_fail = 0;
  int n_tests = 0;
  int cycles = 0;
  // Pulled-up data line
  assign data_w = d_oe ? d_o : (h_oe ? h_d : 1'b1);
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #7;
    forever #32 link_clk_i = ~link_clk_i;
  end
  lcd_serial_core #(.OSC_DIV(4)) lcd_serial_core_inst (
    .clk_i(clk_i), .srst_i(srst_i), .ce_i(ce_i), .link_clk_i(link_clk_i), .cs_n_i(cs_n),
    .wr_n_i(wr_n), .rd_n_i(rd_n), .data_i(data_w), .data_o(d_o), .data_oe_o(d_oe),
    .irq_o(irq_o), .irq_oe_o(irq_oe), .tone_out_pair_o(tone), .tone_out_pair_oe_o(tone_oe),
    .seg_o(seg), .com_o(com), .osc_on_o(osc_on), .bias_gen_on_o(bias_on),
    .bias_third_o(third), .commons_sel_o(coms)
  );
  lcd_host_model lcd_host_model_inst (
    .clk_i(clk_i), .data_i(data_w), .cs_n_o(cs_n), .wr_n_o(wr_n), .rd_n_o(rd_n),
    .data_o(h_d), .data_oe_o(h_oe)
  );
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic open_frame(input logic [2:0] id);
    lcd_host_model_inst.start();
    lcd_host_model_inst.send({13'h0, id}, 3);
  endtask
  task automatic cmd(input logic [7:0] code);
    lcd_host_model_inst.send({7'h0, code, 1'($urandom)}, 9);
  endtask
  task automatic wr_words(input logic [5:0] at, input int n);
    open_frame(ID_WRITE);
    lcd_host_model_inst.send({10'h0, at}, 6);
    for (int k = 0; k < n; k++) begin
      d = 4'($urandom);
      lcd_host_model_inst.send({12'h0, d[0], d[1], d[2], d[3]}, 4);
      mem[5'(at + 6'(k))] = d;
    end
    lcd_host_model_inst.stop();
  endtask
  task automatic rd_words(input logic [5:0] at, input int n);
    open_frame(ID_READ);
    lcd_host_model_inst.send({10'h0, at}, 6);
    for (int k = 0; k < n; k++) begin
      lcd_host_model_inst.recv(v);
      check("read data", v, mem[5'(at + 6'(k))]);
    end
    lcd_host_model_inst.stop();
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      results();
    end
  end
  initial begin
    void'($urandom(32'h1C0CDD97));
    srst_i = 1'b1;
    ce_i = 1'b1;
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    check("osc", osc_on, 1'b0);
    check("bias gen", bias_on, 1'b0);
    check("commons", coms, COMS_RST);
    check("irq", irq_oe, 1'b0);
    $display("test reset done");
    open_frame(ID_CMD);
    cmd(CMD_OSCILLATOR_ON_CMD);
    cmd(CMD_DISPLAY_ON_CMD);
    lcd_host_model_inst.stop();
    check("osc", osc_on, 1'b1);
    check("bias gen", bias_on, 1'b1);
    exp_coms = COMS_RST;
    for (int i = 0; i < 4; i++) begin
      ab = 2'(i);
      c = 1'($urandom);
      open_frame(ID_CMD);
      cmd({GRP_BIAS, ab, 1'b0, c});
      cmd(ab[0] ? CMD_DISPLAY_ON_CMD : CMD_DISPLAY_OFF_CMD);
      lcd_host_model_inst.stop();
      if (ab != COMS_BAD) exp_coms = ab;
      check("commons", coms, exp_coms);
      check("third", third, c);
      check("bias gen", bias_on, ab[0]);
    end
    $display("test config done");
    a = {1'($urandom), 5'h1E};
    wr_words(a, 4);
    open_frame(ID_WRITE);
    lcd_host_model_inst.send({10'h0, a + 6'h3}, 6);
    lcd_host_model_inst.send(16'h0002, 2);
    lcd_host_model_inst.stop();
    rd_words(a, 4);
    open_frame(ID_WRITE);
    lcd_host_model_inst.send({10'h0, a}, 6);
    lcd_host_model_inst.recv(v);
    check("rmw read", v, mem[a[4:0]]);
    d = ~v;
    lcd_host_model_inst.send({12'h0, d[0], d[1], d[2], d[3]}, 4);
    mem[a[4:0]] = d;
    lcd_host_model_inst.stop();
    rd_words(a, 1);
    $display("test memory done");
    for (int i = 0; i < 3; i++) begin
      open_frame(ID_CMD);
      cmd(i == 0 ? {GRP_TONE4K, 5'h0} : (i == 1 ? {GRP_TONE2K, 4'h0} : CMD_TONE_OFF));
      lcd_host_model_inst.stop();
      check("tone oe", tone_oe, i < 2);
      if (i < 2) check("tone pair", tone[1], 1'(~tone[0]));
    end
    $display("test tone done");
    open_frame(ID_CMD);
    cmd({GRP_IRQ, 1'b0, 1'b1, 3'h0});
    cmd(CMD_WDG_EN);
    cmd({CMD_WDG_CLR_HI, 1'b0});
    lcd_host_model_inst.stop();
    repeat (1000) @(posedge clk_i);
    check("irq early", irq_oe, 1'b0);
    repeat (5000) @(posedge clk_i);
    check("irq timeout", irq_oe, 1'b1);
    repeat (3000) @(posedge clk_i);
    check("irq held", irq_oe, 1'b1);
    open_frame(ID_CMD);
    cmd({GRP_FSEL, 1'b0, 4'h6});
    cmd({CMD_WDG_CLR_HI, 1'($urandom)});
    lcd_host_model_inst.stop();
    check("irq cleared", irq_oe, 1'b0);
    repeat (4500) @(posedge clk_i);
    check("irq slow", irq_oe, 1'b0);
    repeat (5000) @(posedge clk_i);
    check("irq slow out", irq_oe, 1'b1);
    open_frame(ID_CMD);
    cmd({GRP_IRQ, 1'b0, 1'b0, 3'h0});
    lcd_host_model_inst.stop();
    check("irq disabled", irq_oe, 1'b0);
    $display("test watchdog done");
    results();
  end
endmodule // lcd_serial_core_tb
`default_nettype wire
